/* File: src/watchdog_period_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module watchdog_period_control #(
  parameter int TICK_CYCLES = `WDT_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wdt_pkg::wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [1:0] config_mode_i,
  input wire logic sleep_i,
  input wire logic kick_i,
  input wire logic osc_fail_i,
  input wire logic ost_running_i,
  output logic reset_req_o,
  output logic wake_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic irq_o
);
  import wdt_pkg::*;

  wdt_state_t r;
  wdt_state_t next_r;
  logic tick;
  logic [4:0] shift;
  logic [`WDT_CNT_W-1:0] term;
  logic running;
  logic clear_cnt;
  logic hit;
  logic bus_req;
  logic [`WDT_EV_W-1:0] ev;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("watchdog_period_control: TICK_CYCLES must be at least 2");
  end

  // ----------------------------------------
  // Low-frequency time base and period
  // ----------------------------------------
  wdt_tick_divider #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  wdt_period_decode u_decode (
    .code_i(r.period),
    .shift_o(shift)
  );

  // ----------------------------------------
  // Run and clear conditions
  // ----------------------------------------
  always_comb begin
    case (config_mode_i)
      `WDT_MODE_ON: running = 1'b1;
      `WDT_MODE_AWAKE: running = !sleep_i;
      `WDT_MODE_SOFT: running = r.soft_en;
      default: running = 1'b0;
    endcase
  end

  assign term = (`WDT_CNT_W'(1) << shift) - `WDT_CNT_W'(1);
  assign clear_cnt = !running || kick_i || osc_fail_i || ost_running_i
                     || (sleep_i != r.prev_sleep);
  assign hit = tick && !clear_cnt && ((r.count & term) == term);
  assign bus_req = wb_i.cyc && wb_i.stb && !r.ack;
  assign ev = {hit && sleep_i, hit && !sleep_i};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.prev_sleep = sleep_i;
    next_r.reset_req = 1'b0;
    next_r.wake = 1'b0;
    next_r.ack = bus_req;
    next_r.rdata = '0;

    if (clear_cnt || hit) begin
      next_r.count = '0;
    end else if (tick) begin
      next_r.count = r.count + `WDT_CNT_W'(1);
    end

    if (hit && !sleep_i) begin
      next_r.reset_req = 1'b1;
      next_r.timeout_flag = 1'b1;
      next_r.powerdown_flag = 1'b0;
    end else if (hit) begin
      next_r.wake = 1'b1;
      next_r.timeout_flag = 1'b1;
      next_r.powerdown_flag = 1'b1;
    end else if (kick_i) begin
      next_r.timeout_flag = 1'b0;
      next_r.powerdown_flag = 1'b0;
    end

    if (bus_req && wb_i.we && wb_i.sel[0]) begin
      if (wb_i.adr == `WDT_OFS_CTRL) begin
        next_r.period = wb_i.dat[`WDT_CTRL_PS_HI:`WDT_CTRL_PS_LO];
        next_r.soft_en = wb_i.dat[`WDT_CTRL_EN_BIT];
      end else if (wb_i.adr == `WDT_OFS_MASK) begin
        next_r.mask = wb_i.dat[`WDT_EV_W-1:0];
      end
    end

    if (bus_req && !wb_i.we) begin
      if (wb_i.adr == `WDT_OFS_CTRL) begin
        next_r.rdata = {26'h0, r.period, r.soft_en};
      end else if (wb_i.adr == `WDT_OFS_STATUS) begin
        next_r.rdata = {30'h0, r.status};
        next_r.status = '0;
      end else if (wb_i.adr == `WDT_OFS_MASK) begin
        next_r.rdata = {30'h0, r.mask};
      end else if (wb_i.adr == `WDT_OFS_FLAGS) begin
        next_r.rdata = {30'h0, r.timeout_flag, r.powerdown_flag};
      end else begin
        next_r.rdata = '0;
      end
    end

    // Set wins over read clear
    next_r.status = next_r.status | ev;
    next_r.irq = |(next_r.status & next_r.mask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.period <= `WDT_PS_RESET;
      r.soft_en <= `WDT_EN_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdata;
  assign reset_req_o = r.reset_req;
  assign wake_o = r.wake;
  assign timeout_flag_o = r.timeout_flag;
  assign powerdown_flag_o = r.powerdown_flag;
  assign irq_o = r.irq;

  // ----------------------------------------
  // Reference period table for the checks
  // ----------------------------------------
  // Expected shift per code, written apart from the decoder
  logic [4:0] ref_shift;

  always_comb begin
    case (r.period)
      5'h00: ref_shift = 5'h05;
      5'h01: ref_shift = 5'h06;
      5'h02: ref_shift = 5'h07;
      5'h03: ref_shift = 5'h08;
      5'h04: ref_shift = 5'h09;
      5'h05: ref_shift = 5'h0A;
      5'h06: ref_shift = 5'h0B;
      5'h07: ref_shift = 5'h0C;
      5'h08: ref_shift = 5'h0D;
      5'h09: ref_shift = 5'h0E;
      5'h0A: ref_shift = 5'h0F;
      5'h0B: ref_shift = 5'h10;
      5'h0C: ref_shift = 5'h11;
      5'h0D: ref_shift = 5'h12;
      5'h0E: ref_shift = 5'h13;
      5'h0F: ref_shift = 5'h14;
      5'h10: ref_shift = 5'h15;
      5'h11: ref_shift = 5'h16;
      5'h12: ref_shift = 5'h17;
      default: ref_shift = 5'h05;
    endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reserved_read_zero_a: assert property (
    (bus_req && !wb_i.we && wb_i.adr == `WDT_OFS_CTRL) |=> (wb_ack_o && wb_dat_o[7:6] == 2'b00
      && wb_dat_o[5:1] == $past(r.period)))
    else $error("control read shows reserved bits or wrong period");

  short_code_decode_a: assert property (
    (r.period <= 5'h0C) |-> (shift == r.period + 5'h05))
    else $error("period code 0..12 decoded wrongly");

  mid_code_decode_a: assert property (
    (r.period >= 5'h0D && r.period <= 5'h0F) |-> (shift == r.period + 5'h05 && shift >= 5'h12))
    else $error("period code 13..15 decoded wrongly");

  long_code_decode_a: assert property (
    (r.period >= 5'h10) |-> (r.period <= 5'h12 ? shift == r.period + 5'h05 : shift == 5'h05))
    else $error("long or reserved period code decoded wrongly");

  reset_defaults_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (r.period == 5'h0B && !r.soft_en && r.count == '0))
    else $error("reset values wrong");

  soft_disable_a: assert property (
    (config_mode_i == 2'b01 && !r.soft_en) [*2] |-> (r.count == '0))
    else $error("count moved with software enable low");

  mode_off_a: assert property (
    (config_mode_i == 2'b00 || (config_mode_i == 2'b10 && sleep_i)) |=> (r.count == '0 && !reset_req_o))
    else $error("watchdog ran in an off mode");

  sleep_timeout_a: assert property (
    (hit && sleep_i) |=> (wake_o && !reset_req_o && timeout_flag_o && powerdown_flag_o) ##1 !wake_o)
    else $error("sleep timeout did not wake cleanly");

  kick_clears_a: assert property (
    (kick_i || osc_fail_i) |=> (r.count == '0))
    else $error("count not cleared");

  awake_timeout_a: assert property (
    (hit && !sleep_i) |=> (reset_req_o && !wake_o) ##1 !reset_req_o)
    else $error("awake timeout did not request one reset pulse");

  irq_level_a: assert property (
    (|(r.status & r.mask)) == irq_o)
    else $error("interrupt output disagrees with status and mask");

  decode_table_a: assert property (
    shift == ref_shift)
    else $error("period decode differs from the code table");

  ctrl_write_a: assert property (
    (bus_req && wb_i.we && wb_i.sel[0] && wb_i.adr == `WDT_OFS_CTRL)
      |=> ({26'h0, r.period, r.soft_en} == ($past(wb_i.dat) & 32'h3F)))
    else $error("control write did not land");

  soft_run_a: assert property (
    (config_mode_i == 2'b01) |-> (running == r.soft_en))
    else $error("software enable bit not obeyed in mode 01");

  hard_modes_a: assert property (
    (config_mode_i != 2'b01)
      |-> (running == (config_mode_i == 2'b11 || (config_mode_i == 2'b10 && !sleep_i))))
    else $error("software enable bit not ignored outside mode 01");

  sleep_edge_clear_a: assert property (
    (sleep_i != r.prev_sleep || ost_running_i) |=> (r.count == '0))
    else $error("count not cleared on sleep change or start-up hold");

  awake_flags_a: assert property (
    (hit && !sleep_i) |=> (timeout_flag_o && !powerdown_flag_o && r.status[`WDT_EV_AWAKE]))
    else $error("awake timeout flags wrong");

  sleep_status_a: assert property (
    (hit && sleep_i) |=> r.status[`WDT_EV_SLEEP])
    else $error("sleep timeout not recorded in status");

  kick_flags_a: assert property (
    kick_i |=> (!timeout_flag_o && !powerdown_flag_o))
    else $error("kick left the timeout flags set");

  reset_outputs_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (!wb_ack_o && !reset_req_o && !wake_o && !irq_o
      && !timeout_flag_o && !powerdown_flag_o))
    else $error("outputs not idle after reset");

  ack_follows_req_a: assert property (
    bus_req |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");

  ack_one_cycle_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge stood longer than one cycle");

  idle_data_zero_a: assert property (
    !wb_ack_o |-> (wb_dat_o == '0))
    else $error("read data shown without acknowledge");

  status_set_wins_a: assert property (
    (bus_req && !wb_i.we && wb_i.adr == `WDT_OFS_STATUS) |=> (r.status == $past(ev)))
    else $error("status read clear lost a new event");

  status_sticky_a: assert property (
    !(bus_req && !wb_i.we && wb_i.adr == `WDT_OFS_STATUS)
      |=> ((r.status & $past(r.status)) == $past(r.status)))
    else $error("status bit dropped without a read");

  tick_single_a: assert property (
    tick |=> !tick)
    else $error("time base pulse stood longer than one cycle");

  awake_reset_c: cover property (hit && !sleep_i);
  sleep_wake_c: cover property (hit && sleep_i);
  ctrl_write_c: cover property (bus_req && wb_i.we && wb_i.adr == `WDT_OFS_CTRL);
  irq_raise_c: cover property ($rose(irq_o));
  status_clear_c: cover property (bus_req && !wb_i.we && wb_i.adr == `WDT_OFS_STATUS && r.status != '0);
endmodule : watchdog_period_control
`default_nettype wire

/* File: src/wdt_cfg.svh */
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------
// Clocks
// ----------------------------------------
`define WDT_CLK_HZ 250000000
`define WDT_LFOSC_HZ 31000
`define WDT_TICK_CYCLES (`WDT_CLK_HZ / `WDT_LFOSC_HZ)

// ----------------------------------------
// Register map
// ----------------------------------------
`define WDT_ADR_W 4
`define WDT_OFS_CTRL 4'h0
`define WDT_OFS_STATUS 4'h4
`define WDT_OFS_MASK 4'h8
`define WDT_OFS_FLAGS 4'hC

// ----------------------------------------
// Control fields
// ----------------------------------------
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_PS_LO 1
`define WDT_CTRL_PS_HI 5
`define WDT_PS_RESET 5'h0B
`define WDT_EN_RESET 1'b0

// ----------------------------------------
// Period decode
// ----------------------------------------
`define WDT_PS_MAX_VALID 5'h12
`define WDT_SHIFT_MIN 5'h05
`define WDT_CNT_W 24

// ----------------------------------------
// Config modes
// ----------------------------------------
`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SOFT 2'h1
`define WDT_MODE_AWAKE 2'h2
`define WDT_MODE_ON 2'h3

// ----------------------------------------
// Status and flag bits
// ----------------------------------------
`define WDT_EV_W 2
`define WDT_EV_AWAKE 0
`define WDT_EV_SLEEP 1

`endif

/* File: src/wdt_period_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_period_decode (
  input wire logic [4:0] code_i,
  output logic [4:0] shift_o
);
  always_comb begin
    if (code_i <= `WDT_PS_MAX_VALID) begin
      shift_o = code_i + `WDT_SHIFT_MIN;
    end else begin
      shift_o = `WDT_SHIFT_MIN;
    end
  end
endmodule : wdt_period_decode
`default_nettype wire

/* File: src/wdt_pkg.sv */
`default_nettype none
`include "wdt_cfg.svh"
package wdt_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`WDT_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [4:0] period;
    logic soft_en;
    logic [`WDT_CNT_W-1:0] count;
    logic prev_sleep;
    logic [`WDT_EV_W-1:0] status;
    logic [`WDT_EV_W-1:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic reset_req;
    logic wake;
    logic timeout_flag;
    logic powerdown_flag;
    logic irq;
  } wdt_state_t;

endpackage : wdt_pkg
`default_nettype wire

/* File: src/wdt_tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_divider #(
  parameter int DIV = 8064
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt;

  if (DIV < 2) begin : g_chk
    $error("wdt_tick_divider: DIV must be at least 2");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt == W'(DIV - 1)) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule : wdt_tick_divider
`default_nettype wire

/* File: test/watchdog_period_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_period_control_tb;
  import wdt_pkg::*;
  localparam int TC = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_i = '0;
  logic [1:0] config_mode_i = 2'h1;
  logic sleep_i = 1'b0;
  logic kick_i = 1'b0;
  logic osc_fail_i = 1'b0;
  logic ost_running_i = 1'b0;
  logic wb_ack_o, reset_req_o, wake_o, timeout_flag_o, powerdown_flag_o, irq_o;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [1:0] ev;
  logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h13, 5'h1F};
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  int n;

  always #2 clk_i = ~clk_i;

  watchdog_period_control #(.TICK_CYCLES(TC)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .config_mode_i(config_mode_i), .sleep_i(sleep_i),
    .kick_i(kick_i), .osc_fail_i(osc_fail_i), .ost_running_i(ost_running_i), .reset_req_o(reset_req_o),
    .wake_o(wake_o), .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o), .irq_o(irq_o));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : cmp

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask : wb

  task automatic rdc(input logic [3:0] adr, input logic [31:0] exp, input string nm);
    wb(1'b0, adr, 32'h0);
    cmp(nm, exp, rd);
  endtask : rdc

  // Cycles until a reset request or wake pulse, capped at lim
  task automatic watch(input int lim);
    n = 0;
    while (n < lim && reset_req_o !== 1'b1 && wake_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    ev = {wake_o, reset_req_o};
  endtask : watch

  task automatic run(input logic [1:0] md, input logic sl, input logic [7:0] ctl, input int lim, input int exp,
    input logic [1:0] xev);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    config_mode_i <= md;
    sleep_i <= sl;
    wb(1'b1, 4'h0, {24'h0, ctl});
    watch(lim);
    cmp("timeout cycles", 32'h1, 32'(n >= exp - 12 && n <= exp + 12));
    cmp("timeout kind", 32'(xev), 32'(ev));
  endtask : run

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(4'h0, 32'h16, "control reset");
    rdc(4'hC, 32'h0, "flags reset");
    wb(1'b1, 4'h0, 32'hC0);
    rdc(4'h0, 32'h0, "control high bits");
    wb(1'b1, 4'h8, 32'h3);
    rdc(4'h8, 32'h3, "mask");
    rdc(4'h2, 32'h0, "unmapped");
    foreach (codes[i]) begin
      run(2'h1, 1'b0, {2'h0, codes[i], 1'b1}, 9000, TC << (codes[i] <= 5'h12 ? int'(codes[i]) + 5 : 5), 2'h1);
    end
    rdc(4'h4, 32'h1, "status awake");
    rdc(4'hC, 32'h2, "flags awake");
    cmp("flag pins awake", 32'h2, 32'({timeout_flag_o, powerdown_flag_o}));
    run(2'h1, 1'b0, 8'h1B, 600, 600, 2'h0);
    run(2'h1, 1'b0, 8'h25, 600, 600, 2'h0);
    run(2'h0, 1'b0, 8'h01, 600, 600, 2'h0);
    run(2'h1, 1'b0, 8'h00, 600, 600, 2'h0);
    run(2'h3, 1'b0, 8'h00, 900, 32 * TC, 2'h1);
    run(2'h2, 1'b1, 8'h01, 600, 600, 2'h0);
    run(2'h3, 1'b1, 8'h01, 900, 32 * TC, 2'h2);
    repeat (2) @(posedge clk_i);
    cmp("irq masked", 32'h0, 32'(irq_o));
    rdc(4'hC, 32'h3, "flags sleep");
    cmp("flag pins sleep", 32'h3, 32'({timeout_flag_o, powerdown_flag_o}));
    wb(1'b1, 4'h8, 32'h2);
    repeat (2) @(posedge clk_i);
    cmp("irq set", 32'h1, 32'(irq_o));
    rdc(4'h4, 32'h2, "status sleep");
    repeat (2) @(posedge clk_i);
    cmp("irq cleared", 32'h0, 32'(irq_o));
    sleep_i <= 1'b0;
    repeat (6) begin
      kick_i <= 1'b1;
      @(posedge clk_i);
      kick_i <= 1'b0;
      watch(90);
      cmp("kick holds off", 32'h0, 32'(ev));
    end
    rdc(4'hC, 32'h0, "flags kicked");
    cmp("flag pins kicked", 32'h0, 32'({timeout_flag_o, powerdown_flag_o}));
    osc_fail_i <= 1'b1;
    watch(600);
    cmp("osc fail holds", 32'h0, 32'(ev));
    osc_fail_i <= 1'b0;
    ost_running_i <= 1'b1;
    watch(600);
    cmp("start timer holds", 32'h0, 32'(ev));
    ost_running_i <= 1'b0;
    watch(900);
    cmp("count resumes", 32'h1, 32'(ev));
    tally_and_finish();
  end
endmodule : watchdog_period_control_tb
`default_nettype wire
